// ===== core/fma_map.svh
// Purpose: Constants for the fractional data arithmetic unit
// Assumes: Included by the package and the design modules
// Notes:   Widths, limit values and reset values
// Summary of operation
// - Four input words, two extended accumulators
// - Multiplier is parallel, single cycle, unpipelined
// - All arithmetic is signed two's-complement fraction
// - Registers move as 24 or 48 bits
// - Every operation finishes in one cycle
// - Operands come only from own registers
// - Arithmetic writes full 56 bits to accumulator
// - Logical ops use 24-bit words only
// - Read shifter passes, doubles or halves value
// - Each shifter gives long word plus overflow flag
// - Scaling mode input picks shift direction
// - Unrepresentable sums and reads become largest same-sign value
// - Reads of extended accumulators are limited
// - Limit after shifting, never before
// - Two independent limiters, or one long limiter
// - X memory uses x bus, Y uses y
// - Both buses join for long moves
`ifndef FMA_MAP_SVH
`define FMA_MAP_SVH
`define FMA_WORD_W    24
`define FMA_LONG_W    48
`define FMA_ACC_W     56
`define FMA_EXT_W     8
`define FMA_REG_RST   24'h000000
`define FMA_ACC_RST   56'h00000000000000
`define FMA_POS_MAX48 48'h7fffffffffff
`define FMA_NEG_MAX48 48'h800000000000
`define FMA_POS_MAX56 56'h7fffffffffffff
`define FMA_NEG_MAX56 56'h80000000000000
`define FMA_RND_HALF  24'h800000
`define FMA_LOW_ZERO  24'h000000
`endif

// ===== core/fma_pkg.sv
// Purpose: Types of the fractional data arithmetic unit
// Assumes: fma_map.svh on the include path
// Notes:   Operation, register select and scaling codes
`include "fma_map.svh"
package fma_pkg;
    typedef logic [`FMA_WORD_W-1:0] fma_word_t;
    typedef logic [`FMA_ACC_W-1:0]  fma_acc_t;
    typedef enum logic [3:0] {
        FMA_OP_NOP  = 4'h0,
        FMA_OP_MPY  = 4'h1,
        FMA_OP_MAC  = 4'h2,
        FMA_OP_MPYR = 4'h3,
        FMA_OP_MACR = 4'h4,
        FMA_OP_ADD  = 4'h5,
        FMA_OP_SUB  = 4'h6,
        FMA_OP_DIV  = 4'h7,
        FMA_OP_NORM = 4'h8,
        FMA_OP_ASL  = 4'h9,
        FMA_OP_ASR  = 4'ha,
        FMA_OP_AND  = 4'hb,
        FMA_OP_OR   = 4'hc,
        FMA_OP_EOR  = 4'hd
    } fma_op_t;
    typedef enum logic [2:0] {
        FMA_R_X0 = 3'h0,
        FMA_R_X1 = 3'h1,
        FMA_R_Y0 = 3'h2,
        FMA_R_Y1 = 3'h3,
        FMA_R_A  = 3'h4,
        FMA_R_B  = 3'h5
    } fma_reg_t;
    typedef enum logic [1:0] {
        FMA_L_X = 2'h0,
        FMA_L_Y = 2'h1,
        FMA_L_A = 2'h2,
        FMA_L_B = 2'h3
    } fma_long_t;
    typedef enum logic [1:0] {
        FMA_SC_NONE = 2'h0,
        FMA_SC_DOWN = 2'h1,
        FMA_SC_UP   = 2'h2
    } fma_scale_t;
endpackage

// ===== core/fma_shift_limit.sv
// Purpose: Output shifter and limiter for one accumulator
// Assumes: Combinational; the caller registers the result
// Notes:   Reserved scaling code acts as no shift
`timescale 1ns/10ps
`default_nettype none
`include "fma_map.svh"
module fma_shift_limit (
    // Accumulator value and scaling
    input  wire logic [`FMA_ACC_W-1:0]  acc_in,
    input  wire fma_pkg::fma_scale_t    scale_mode,
    // Scaled and limited long word
    output logic      [`FMA_LONG_W-1:0] limited,
    output logic                        overflow
);
    import fma_pkg::*;

    logic [`FMA_ACC_W:0] shifted;

    ////////////////////////////////////////////////////////////////////////
    // Scale first, then limit the scaled value
    always_comb begin
        unique case (scale_mode)
            FMA_SC_NONE: shifted = {acc_in[`FMA_ACC_W-1], acc_in};
            FMA_SC_DOWN: shifted = {{2{acc_in[`FMA_ACC_W-1]}}, acc_in[`FMA_ACC_W-1:1]};
            FMA_SC_UP:   shifted = {acc_in, 1'b0};
            default:     shifted = {acc_in[`FMA_ACC_W-1], acc_in};
        endcase
        overflow = shifted[`FMA_ACC_W:`FMA_LONG_W-1] !=
                   {(`FMA_EXT_W + 2){shifted[`FMA_LONG_W-1]}};
        if (overflow) begin
            limited = shifted[`FMA_ACC_W] ? `FMA_NEG_MAX48 : `FMA_POS_MAX48;
        end else begin
            limited = shifted[`FMA_LONG_W-1:0];
        end
    end
endmodule
`default_nettype wire

// ===== core/fma_data_alu.sv
// Purpose: Fractional multiply-accumulate data arithmetic unit
// Assumes: Requests and bus data come from logic on ref_clk
// Notes:   Bus reads appear one cycle after the request
`timescale 1ns/10ps
`default_nettype none
`include "fma_map.svh"
module fma_data_alu (
    // Clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   reset,
    // Operation request
    input  wire logic                   op_valid,
    input  wire fma_pkg::fma_op_t       op_code,
    input  wire logic                   op_neg,
    input  wire logic [1:0]             op_src1,
    input  wire logic [1:0]             op_src2,
    input  wire logic                   op_dst,
    // Scaling mode from status register
    input  wire fma_pkg::fma_scale_t    scale_mode,
    // Operand bus writes
    input  wire logic                   x_wr_en,
    input  wire fma_pkg::fma_reg_t      x_wr_sel,
    input  wire logic [`FMA_WORD_W-1:0] x_bus_in,
    input  wire logic                   y_wr_en,
    input  wire fma_pkg::fma_reg_t      y_wr_sel,
    input  wire logic [`FMA_WORD_W-1:0] y_bus_in,
    input  wire logic                   long_wr_en,
    input  wire fma_pkg::fma_long_t     long_wr_sel,
    // Operand bus read requests
    input  wire logic                   x_rd_en,
    input  wire fma_pkg::fma_reg_t      x_rd_sel,
    input  wire logic                   y_rd_en,
    input  wire fma_pkg::fma_reg_t      y_rd_sel,
    input  wire logic                   long_rd_en,
    input  wire fma_pkg::fma_long_t     long_rd_sel,
    // Operand bus drive
    output logic [`FMA_WORD_W-1:0]      x_bus_out,
    output logic                        x_bus_oe_n,
    output logic                        x_limit,
    output logic [`FMA_WORD_W-1:0]      y_bus_out,
    output logic                        y_bus_oe_n,
    output logic                        y_limit,
    // Accumulator state
    output logic [`FMA_ACC_W-1:0]       acc_a,
    output logic [`FMA_ACC_W-1:0]       acc_b
);
    import fma_pkg::*;

    localparam int ACC_MSB  = `FMA_ACC_W - 1;
    localparam int LONG_MSB = `FMA_LONG_W - 1;
    localparam int WORD_MSB = `FMA_WORD_W - 1;

    fma_word_t               in_ff [4];
    fma_word_t               nxt_in [4];
    fma_acc_t                acc_ff [2];
    fma_acc_t                nxt_acc [2];
    fma_acc_t                dst_v;
    fma_acc_t                opnd;
    fma_acc_t                frac;
    fma_acc_t                mterm;
    fma_acc_t                tshift;
    fma_acc_t                res;
    logic signed [LONG_MSB:0] prod;
    logic [1:0]              wr_en_v;
    fma_reg_t                wr_sel_v [2];
    fma_word_t               wr_dat_v [2];
    logic [1:0]              rd_en_v;
    fma_reg_t                rd_sel_v [2];
    logic [LONG_MSB:0]       lim [2];
    logic [1:0]              ovf;
    fma_word_t               bus_ff [2];
    fma_word_t               nxt_bus [2];
    logic [1:0]              oe_n_ff;
    logic [1:0]              nxt_oe_n;
    logic [1:0]              lim_ff;
    logic [1:0]              nxt_lim;

    ////////////////////////////////////////////////////////////////////////
    // Saturating signed 56-bit add
    function automatic fma_acc_t sat_add(input fma_acc_t a, input fma_acc_t b);
        logic [`FMA_ACC_W:0] sum;
        sum = {a[ACC_MSB], a} + {b[ACC_MSB], b};
        if (sum[`FMA_ACC_W] != sum[ACC_MSB]) begin
            sat_add = sum[`FMA_ACC_W] ? `FMA_NEG_MAX56 : `FMA_POS_MAX56;
        end else begin
            sat_add = sum[ACC_MSB:0];
        end
    endfunction

    function automatic fma_acc_t word_to_acc(input fma_word_t w);
        word_to_acc = {{`FMA_EXT_W{w[WORD_MSB]}}, w, `FMA_LOW_ZERO};
    endfunction

    function automatic fma_acc_t conv_round(input fma_acc_t v);
        fma_acc_t r;
        r = sat_add(v, fma_acc_t'(`FMA_RND_HALF));
        if (v[WORD_MSB:0] == `FMA_RND_HALF) begin
            r[`FMA_WORD_W] = 1'b0;
        end
        r[WORD_MSB:0] = `FMA_LOW_ZERO;
        conv_round = r;
    endfunction

    function automatic logic ext_used(input fma_acc_t v);
        ext_used = v[ACC_MSB:LONG_MSB] != {(`FMA_EXT_W + 1){v[LONG_MSB]}};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Per-bus request vectors
    assign wr_en_v     = {y_wr_en, x_wr_en};
    assign wr_sel_v[0] = x_wr_sel;
    assign wr_sel_v[1] = y_wr_sel;
    assign wr_dat_v[0] = x_bus_in;
    assign wr_dat_v[1] = y_bus_in;
    assign rd_en_v     = {y_rd_en, x_rd_en};
    assign rd_sel_v[0] = x_rd_sel;
    assign rd_sel_v[1] = y_rd_sel;

    ////////////////////////////////////////////////////////////////////////
    // Register file and arithmetic next state
    always_comb begin
        nxt_in  = in_ff;
        nxt_acc = acc_ff;
        dst_v   = acc_ff[op_dst];
        opnd    = word_to_acc(in_ff[op_src1]);
        prod    = $signed(in_ff[op_src1]) * $signed(in_ff[op_src2]);
        frac    = {{(`FMA_EXT_W - 1){prod[LONG_MSB]}}, prod, 1'b0};
        mterm   = op_neg ? fma_acc_t'(-frac) : frac;
        tshift  = {dst_v[ACC_MSB-1:0], 1'b0};
        res     = dst_v;
        unique case (op_code)
            FMA_OP_NOP:  res = dst_v;
            FMA_OP_MPY:  res = mterm;
            FMA_OP_MAC:  res = sat_add(dst_v, mterm);
            FMA_OP_MPYR: res = conv_round(mterm);
            FMA_OP_MACR: res = conv_round(sat_add(dst_v, mterm));
            FMA_OP_ADD:  res = sat_add(dst_v, opnd);
            FMA_OP_SUB:  res = sat_add(dst_v, fma_acc_t'(-opnd));
            FMA_OP_DIV: begin
                res    = (dst_v[ACC_MSB] ^ opnd[ACC_MSB]) ? tshift + opnd : tshift - opnd;
                res[0] = ~(dst_v[ACC_MSB] ^ opnd[ACC_MSB]);
            end
            FMA_OP_NORM: begin
                if (ext_used(dst_v)) begin
                    res = {dst_v[ACC_MSB], dst_v[ACC_MSB:1]};
                end else if (dst_v[LONG_MSB] == dst_v[LONG_MSB-1]) begin
                    res = tshift;
                end
            end
            FMA_OP_ASL:  res = tshift;
            FMA_OP_ASR:  res = {dst_v[ACC_MSB], dst_v[ACC_MSB:1]};
            FMA_OP_AND:  res[LONG_MSB:`FMA_WORD_W] = dst_v[LONG_MSB:`FMA_WORD_W] & in_ff[op_src1];
            FMA_OP_OR:   res[LONG_MSB:`FMA_WORD_W] = dst_v[LONG_MSB:`FMA_WORD_W] | in_ff[op_src1];
            FMA_OP_EOR:  res[LONG_MSB:`FMA_WORD_W] = dst_v[LONG_MSB:`FMA_WORD_W] ^ in_ff[op_src1];
            default:     res = dst_v;
        endcase
        if (op_valid) begin
            nxt_acc[op_dst] = res;
        end
        for (int p = 0; p < 2; p++) begin
            if (wr_en_v[p]) begin
                if (wr_sel_v[p] == FMA_R_A || wr_sel_v[p] == FMA_R_B) begin
                    nxt_acc[wr_sel_v[p][0]] = word_to_acc(wr_dat_v[p]);
                end else if (!wr_sel_v[p][2]) begin
                    nxt_in[wr_sel_v[p][1:0]] = wr_dat_v[p];
                end
            end
        end
        if (long_wr_en) begin
            unique case (long_wr_sel)
                FMA_L_X: begin
                    nxt_in[1] = x_bus_in;
                    nxt_in[0] = y_bus_in;
                end
                FMA_L_Y: begin
                    nxt_in[3] = x_bus_in;
                    nxt_in[2] = y_bus_in;
                end
                FMA_L_A, FMA_L_B: begin
                    nxt_acc[long_wr_sel[0]] = {{`FMA_EXT_W{x_bus_in[WORD_MSB]}}, x_bus_in, y_bus_in};
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < 4; i++) begin
                in_ff[i] <= `FMA_REG_RST;
            end
            acc_ff[0] <= `FMA_ACC_RST;
            acc_ff[1] <= `FMA_ACC_RST;
        end else begin
            in_ff  <= nxt_in;
            acc_ff <= nxt_acc;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // one limiter per accumulator
    fma_shift_limit u_lim_a (
        .acc_in     (acc_ff[0]),
        .scale_mode (scale_mode),
        .limited    (lim[0]),
        .overflow   (ovf[0])
    );

    fma_shift_limit u_lim_b (
        .acc_in     (acc_ff[1]),
        .scale_mode (scale_mode),
        .limited    (lim[1]),
        .overflow   (ovf[1])
    );

    ////////////////////////////////////////////////////////////////////////
    // Bus read next state
    always_comb begin
        nxt_bus[0] = `FMA_REG_RST;
        nxt_bus[1] = `FMA_REG_RST;
        nxt_oe_n   = 2'h3;
        nxt_lim    = 2'h0;
        for (int p = 0; p < 2; p++) begin
            if (rd_en_v[p]) begin
                nxt_oe_n[p] = 1'b0;
                if (rd_sel_v[p] == FMA_R_A || rd_sel_v[p] == FMA_R_B) begin
                    nxt_bus[p] = lim[rd_sel_v[p][0]][LONG_MSB:`FMA_WORD_W];
                    nxt_lim[p] = ovf[rd_sel_v[p][0]];
                end else if (!rd_sel_v[p][2]) begin
                    nxt_bus[p] = in_ff[rd_sel_v[p][1:0]];
                end
            end
        end
        if (long_rd_en) begin
            nxt_oe_n = 2'h0;
            nxt_lim  = 2'h0;
            unique case (long_rd_sel)
                FMA_L_X: begin
                    nxt_bus[0] = in_ff[1];
                    nxt_bus[1] = in_ff[0];
                end
                FMA_L_Y: begin
                    nxt_bus[0] = in_ff[3];
                    nxt_bus[1] = in_ff[2];
                end
                FMA_L_A, FMA_L_B: begin
                    {nxt_bus[0], nxt_bus[1]} = lim[long_rd_sel[0]];
                    nxt_lim = {2{ovf[long_rd_sel[0]]}};
                end
            endcase
        end
    end

    // Bus drive registers
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            bus_ff[0] <= `FMA_REG_RST;
            bus_ff[1] <= `FMA_REG_RST;
            oe_n_ff   <= 2'h3;
            lim_ff    <= 2'h0;
        end else begin
            bus_ff  <= nxt_bus;
            oe_n_ff <= nxt_oe_n;
            lim_ff  <= nxt_lim;
        end
    end

    // Outputs straight from flops
    assign x_bus_out  = bus_ff[0];
    assign y_bus_out  = bus_ff[1];
    assign x_bus_oe_n = oe_n_ff[0];
    assign y_bus_oe_n = oe_n_ff[1];
    assign x_limit    = lim_ff[0];
    assign y_limit    = lim_ff[1];
    assign acc_a      = acc_ff[0];
    assign acc_b      = acc_ff[1];

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    logic quiet;
    assign quiet = !x_wr_en && !y_wr_en && !long_wr_en;

    sequence s_op_a(fma_op_t c);
        op_valid && op_code == c && !op_dst && quiet;
    endsequence

    sequence s_rd_a_x(fma_scale_t m);
        x_rd_en && x_rd_sel == FMA_R_A && !long_rd_en && scale_mode == m;
    endsequence

    property p_mpy_one_cycle;
        s_op_a(FMA_OP_MPY) ##0 (!op_neg && op_src1 == 2'h0 && op_src2 == 2'h0 && in_ff[0] == 24'h400000)
            |=> acc_ff[0] == 56'h00200000000000;
    endproperty
    a_mpy_one_cycle: assert property (p_mpy_one_cycle)
        else $error("Half squared not a quarter next cycle");

    property p_signed_mpy;
        s_op_a(FMA_OP_MPY) ##0 (!op_neg && op_src1 == 2'h0 && op_src2 == 2'h1
            && in_ff[0] == 24'h800000 && in_ff[1] == 24'h400000)
            |=> acc_ff[0] == 56'hffc00000000000;
    endproperty
    a_signed_mpy: assert property (p_signed_mpy)
        else $error("Minus one times half wrong");

    property p_round_low;
        (s_op_a(FMA_OP_MPYR) or s_op_a(FMA_OP_MACR)) |=> acc_ff[0][WORD_MSB:0] == `FMA_LOW_ZERO;
    endproperty
    a_round_low: assert property (p_round_low)
        else $error("Rounded result keeps low word");

    property p_add_sat;
        s_op_a(FMA_OP_ADD) ##0 (acc_ff[0] == 56'h7fff0000000000 && in_ff[op_src1] == 24'h7fffff)
            |=> acc_ff[0] == `FMA_POS_MAX56;
    endproperty
    a_add_sat: assert property (p_add_sat)
        else $error("Overflowing add not limited");

    property p_logic_keep;
        s_op_a(FMA_OP_AND) |=> acc_ff[0][ACC_MSB:`FMA_LONG_W] == $past(acc_ff[0][ACC_MSB:`FMA_LONG_W])
            && acc_ff[0][WORD_MSB:0] == $past(acc_ff[0][WORD_MSB:0]);
    endproperty
    a_logic_keep: assert property (p_logic_keep)
        else $error("Logical op touched extension or low word");

    property p_limit_read;
        s_rd_a_x(FMA_SC_NONE) ##0 ext_used(acc_ff[0])
            |=> x_limit && !x_bus_oe_n && (x_bus_out == 24'h7fffff || x_bus_out == 24'h800000);
    endproperty
    a_limit_read: assert property (p_limit_read)
        else $error("Extended accumulator read not limited");

    property p_scale_up;
        s_rd_a_x(FMA_SC_UP) ##0 (!ext_used(acc_ff[0]) && acc_ff[0][LONG_MSB] == acc_ff[0][LONG_MSB-1])
            |=> !x_limit && x_bus_out == $past(acc_ff[0][LONG_MSB-1:`FMA_WORD_W-1]);
    endproperty
    a_scale_up: assert property (p_scale_up)
        else $error("Scale up read not doubled");

    property p_scale_down;
        s_rd_a_x(FMA_SC_DOWN) ##0 (acc_ff[0][ACC_MSB:`FMA_LONG_W] == 8'h00 && acc_ff[0][LONG_MSB])
            |=> !x_limit && x_bus_out == $past(acc_ff[0][`FMA_LONG_W:`FMA_WORD_W+1]);
    endproperty
    a_scale_down: assert property (p_scale_down)
        else $error("Halved read was limited first");

    property p_oe_timing;
        (x_rd_en || long_rd_en) |=> !x_bus_oe_n ##1 ($past(x_rd_en || long_rd_en) || x_bus_oe_n);
    endproperty
    a_oe_timing: assert property (p_oe_timing)
        else $error("Bus drive not one cycle per request");

    property p_long_read;
        long_rd_en && long_rd_sel == FMA_L_X |=> {x_bus_out, y_bus_out} == $past({in_ff[1], in_ff[0]});
    endproperty
    a_long_read: assert property (p_long_read)
        else $error("Long read halves misplaced");

    property p_word_write;
        x_wr_en && x_wr_sel == FMA_R_X0 && !long_wr_en |=> in_ff[0] == $past(x_bus_in);
    endproperty
    a_word_write: assert property (p_word_write)
        else $error("Word write lost");
endmodule
`default_nettype wire

// ===== test/fma_mem_model.sv
// Purpose: X and Y data memory partner on the operand buses
// Assumes: Unit drives a bus while its oe_n is low
// Notes:   Keeps the last word the unit stored on each bus
`timescale 1ns/10ps
`default_nettype none
module fma_mem_model
    import fma_pkg::*;
(
    // Clock
    input  wire logic      ref_clk,
    // Operand buses from the unit
    input  wire fma_word_t x_bus_out,
    input  wire logic      x_bus_oe_n,
    input  wire fma_word_t y_bus_out,
    input  wire logic      y_bus_oe_n,
    // Stored words
    output fma_word_t      x_mem,
    output fma_word_t      y_mem
);
    ////////////////////////////////////////////////////////////////
    // X memory on x bus, Y memory on y bus
    // long moves fill both memories at once
    always @(posedge ref_clk) begin
        if (!x_bus_oe_n) x_mem <= x_bus_out;
        if (!y_bus_oe_n) y_mem <= y_bus_out;
    end
endmodule
`default_nettype wire

// ===== test/fma_data_alu_test.sv
// Purpose: Self-checking bench of the data arithmetic unit
// Assumes: Inputs change on falling edges
// Notes:   Each scenario task except t_reset drives and judges its own results
`timescale 1ns/10ps
`default_nettype none
module fma_data_alu_test;
    import fma_pkg::*;
    logic ref_clk = 0, reset = 1, op_valid = 0, op_neg = 0, op_dst = 0;
    logic x_wr_en = 0, y_wr_en = 0, long_wr_en = 0, x_rd_en = 0, y_rd_en = 0, long_rd_en = 0;
    logic [1:0] op_src1 = 0, op_src2 = 0;
    fma_op_t    op_code = FMA_OP_NOP;
    fma_scale_t scale_mode = FMA_SC_NONE;
    fma_reg_t   x_wr_sel = FMA_R_X0, y_wr_sel = FMA_R_Y0, x_rd_sel = FMA_R_A, y_rd_sel = FMA_R_A;
    fma_long_t  long_wr_sel = FMA_L_A, long_rd_sel = FMA_L_A;
    fma_word_t  x_bus_in = 0, y_bus_in = 0, x_bus_out, y_bus_out, x_mem, y_mem;
    logic       x_bus_oe_n, y_bus_oe_n, x_limit, y_limit;
    fma_acc_t   acc_a, acc_b;
    int         num_errors = 0, check_count = 0;

    fma_data_alu i_fma_data_alu (.ref_clk(ref_clk), .reset(reset), .op_valid(op_valid),
        .op_code(op_code), .op_neg(op_neg), .op_src1(op_src1), .op_src2(op_src2), .op_dst(op_dst),
        .scale_mode(scale_mode), .x_wr_en(x_wr_en), .x_wr_sel(x_wr_sel), .x_bus_in(x_bus_in),
        .y_wr_en(y_wr_en), .y_wr_sel(y_wr_sel), .y_bus_in(y_bus_in), .long_wr_en(long_wr_en),
        .long_wr_sel(long_wr_sel), .x_rd_en(x_rd_en), .x_rd_sel(x_rd_sel), .y_rd_en(y_rd_en),
        .y_rd_sel(y_rd_sel), .long_rd_en(long_rd_en), .long_rd_sel(long_rd_sel),
        .x_bus_out(x_bus_out), .x_bus_oe_n(x_bus_oe_n), .x_limit(x_limit), .y_bus_out(y_bus_out),
        .y_bus_oe_n(y_bus_oe_n), .y_limit(y_limit), .acc_a(acc_a), .acc_b(acc_b));
    fma_mem_model i_fma_mem_model (.ref_clk(ref_clk), .x_bus_out(x_bus_out),
        .x_bus_oe_n(x_bus_oe_n), .y_bus_out(y_bus_out), .y_bus_oe_n(y_bus_oe_n),
        .x_mem(x_mem), .y_mem(y_mem));

    ////////////////////////////////////////////////////////////////
    // Clock and watchdog
    always #10 ref_clk = ~ref_clk;
    initial begin
        repeat (5000) @(posedge ref_clk);
        num_errors++;
        test_done;
    end

    ////////////////////////////////////////////////////////////////
    // Compare and finish
    task chk(string n, fma_acc_t s, fma_acc_t e);
        check_count++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask
    task test_done;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    // Bus and operation helpers, two cycles each except rl, which takes three
    task op(fma_op_t c, logic n, logic [1:0] s1, logic [1:0] s2, logic d);
        @(negedge ref_clk);
        {op_valid, op_code, op_neg, op_src1, op_src2, op_dst} = {1'b1, c, n, s1, s2, d};
        @(negedge ref_clk);
        op_valid = 0;
    endtask
    task wr(logic y, fma_reg_t s, fma_word_t d);
        @(negedge ref_clk);
        if (y) {y_wr_en, y_wr_sel, y_bus_in} = {1'b1, s, d};
        else {x_wr_en, x_wr_sel, x_bus_in} = {1'b1, s, d};
        @(negedge ref_clk);
        {x_wr_en, y_wr_en} = 2'b00;
    endtask
    task wl(fma_long_t s, fma_word_t hi, fma_word_t lo);
        @(negedge ref_clk);
        {long_wr_en, long_wr_sel, x_bus_in, y_bus_in} = {1'b1, s, hi, lo};
        @(negedge ref_clk);
        long_wr_en = 0;
    endtask
    // Word read: data, oe_n low and limit one cycle after request
    task rd(logic y, fma_reg_t s, fma_scale_t m, fma_word_t e, logic l);
        @(negedge ref_clk);
        scale_mode = m;
        if (y) {y_rd_en, y_rd_sel} = {1'b1, s};
        else {x_rd_en, x_rd_sel} = {1'b1, s};
        @(negedge ref_clk);
        {x_rd_en, y_rd_en} = 2'b00;
        if (y) chk("y read", {y_bus_oe_n, y_limit, y_bus_out}, {1'b0, l, e});
        else chk("x read", {x_bus_oe_n, x_limit, x_bus_out}, {1'b0, l, e});
    endtask
    task rl(fma_long_t s, fma_word_t hi, fma_word_t lo, logic l);
        @(negedge ref_clk);
        {long_rd_en, long_rd_sel, scale_mode} = {1'b1, s, FMA_SC_NONE};
        @(negedge ref_clk);
        long_rd_en = 0;
        chk("long read", {x_limit, y_limit, x_bus_out, y_bus_out}, {l, l, hi, lo});
        @(negedge ref_clk);
        chk("bus release", {x_bus_oe_n, y_bus_oe_n}, 2'b11);
        chk("memories", {x_mem, y_mem}, {hi, lo});
    endtask

    ////////////////////////////////////////////////////////////////
    // Scenarios
    task t_reset;
        chk("reset acc a", acc_a, 56'h0);
        chk("reset acc b", acc_b, 56'h0);
        chk("reset bus", {x_bus_oe_n, y_bus_oe_n, x_limit, y_limit}, 4'hc);
    endtask
    task t_mult;
        wr(0, FMA_R_X0, 24'h400000);
        wr(1, FMA_R_Y0, 24'h400000);
        op(FMA_OP_MPY, 0, 2'h0, 2'h0, 0);
        chk("mpy", acc_a, 56'h00200000000000);
        op(FMA_OP_MAC, 1, 2'h0, 2'h2, 0);
        chk("mac neg", acc_a, 56'h00000000000000);
        wr(0, FMA_R_X1, 24'h800000);
        wr(0, FMA_R_Y1, 24'h800000);
        op(FMA_OP_MPY, 0, 2'h1, 2'h3, 1);
        chk("mpy min", acc_b, 56'h00800000000000);
        rd(1, FMA_R_B, FMA_SC_NONE, 24'h7fffff, 1);
        rl(FMA_L_B, 24'h7fffff, 24'hffffff, 1);
    endtask
    task t_scale;
        wr(0, FMA_R_A, 24'h200000);
        chk("word wr", acc_a, 56'h00200000000000);
        rd(0, FMA_R_A, FMA_SC_UP, 24'h400000, 0);
        rd(1, FMA_R_A, FMA_SC_DOWN, 24'h100000, 0);
        wr(0, FMA_R_A, 24'h600000);
        rd(0, FMA_R_A, FMA_SC_NONE, 24'h600000, 0);
        rd(0, FMA_R_A, FMA_SC_UP, 24'h7fffff, 1);
    endtask
    task t_arith;
        op(FMA_OP_ADD, 0, 2'h0, 2'h0, 0);
        chk("add", acc_a, 56'h00a00000000000);
        rd(0, FMA_R_A, FMA_SC_NONE, 24'h7fffff, 1);
        rd(0, FMA_R_A, FMA_SC_DOWN, 24'h500000, 0);
        op(FMA_OP_SUB, 0, 2'h0, 2'h0, 0);
        chk("sub", acc_a, 56'h00600000000000);
        wl(FMA_L_A, 24'h123456, 24'h789abc);
        rl(FMA_L_A, 24'h123456, 24'h789abc, 0);
    endtask
    task t_logic;
        wl(FMA_L_A, 24'hff0000, 24'h123456);
        wr(0, FMA_R_X0, 24'h0f0f0f);
        op(FMA_OP_AND, 0, 2'h0, 2'h0, 0);
        chk("and", acc_a, 56'hff0f0000123456);
        op(FMA_OP_EOR, 0, 2'h0, 2'h0, 0);
        chk("eor", acc_a, 56'hff000f0f123456);
        op(FMA_OP_OR, 0, 2'h0, 2'h0, 0);
        chk("or", acc_a, 56'hff0f0f0f123456);
    endtask
    // Exact half-way products round toward even
    task t_round;
        wr(0, FMA_R_X0, 24'h000001);
        op(FMA_OP_MPYR, 0, 2'h0, 2'h2, 0);
        chk("mpyr tie", acc_a, 56'h0);
        wr(0, FMA_R_X0, 24'h000003);
        op(FMA_OP_MPYR, 0, 2'h0, 2'h2, 0);
        chk("mpyr odd", acc_a, 56'h00000002000000);
        wr(0, FMA_R_X0, 24'h000001);
        op(FMA_OP_MACR, 0, 2'h0, 2'h2, 0);
        chk("macr tie", acc_a, 56'h00000002000000);
    endtask
    // Sign, shifts, divide step, long moves, saturating add
    task t_ops;
        wr(0, FMA_R_X0, 24'h800000);
        wr(0, FMA_R_X1, 24'h400000);
        op(FMA_OP_MPY, 0, 2'h0, 2'h1, 0);
        chk("mpy sign", acc_a, 56'hffc00000000000);
        op(FMA_OP_ASR, 0, 2'h0, 2'h0, 0);
        chk("asr", acc_a, 56'hffe00000000000);
        op(FMA_OP_NORM, 0, 2'h0, 2'h0, 0);
        chk("norm", acc_a, 56'hffc00000000000);
        op(FMA_OP_DIV, 0, 2'h0, 2'h0, 0);
        chk("div", acc_a, 56'h00000000000001);
        wl(FMA_L_X, 24'habcdef, 24'h123456);
        rl(FMA_L_X, 24'habcdef, 24'h123456, 0);
        wl(FMA_L_Y, 24'h654321, 24'hfedcba);
        rl(FMA_L_Y, 24'h654321, 24'hfedcba, 0);
        rd(1, FMA_R_Y1, FMA_SC_UP, 24'h654321, 0);
        wr(0, FMA_R_A, 24'h7fff00);
        repeat (8) op(FMA_OP_ASL, 0, 2'h0, 2'h0, 0);
        chk("asl", acc_a, 56'h7fff0000000000);
        wr(0, FMA_R_X0, 24'h7fffff);
        op(FMA_OP_ADD, 0, 2'h0, 2'h0, 0);
        chk("add sat", acc_a, 56'h7fffffffffffff);
    endtask

    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (8) @(negedge ref_clk);
        t_reset;
        reset = 0;
        t_mult;
        t_scale;
        t_arith;
        t_logic;
        t_round;
        t_ops;
        test_done;
    end
endmodule
`default_nettype wire
